// [src/tmr_consts.vh]
`ifndef TMR_CONSTS_VH
`define TMR_CONSTS_VH

// Register byte offsets
`define TMR_OFS_CTRL 4'h0
`define TMR_OFS_LOAD 4'h4
`define TMR_OFS_CMP 4'h8
`define TMR_OFS_COUNT 4'hc

// Control/status field positions
`define TMR_BIT_RUN 0
`define TMR_BIT_OVF_IE 1
`define TMR_BIT_CMP_IE 2
`define TMR_MODE_LO 4
`define TMR_MODE_HI 7
`define TMR_BIT_INV 8
`define TMR_BIT_DIR 9
`define TMR_BIT_GPO 10
`define TMR_BIT_GPI 11
`define TMR_BIT_CMP_FLAG 12
`define TMR_BIT_OVF_FLAG 13

// Mode codes
`define TMR_MODE_GPIO 4'h0
`define TMR_MODE_PULSE 4'h1
`define TMR_MODE_TOGGLE 4'h2
`define TMR_MODE_EVENT 4'h3
`define TMR_MODE_WIDTH 4'h4
`define TMR_MODE_PERIOD 4'h5

// Reset values and limits
`define TMR_RST_MODE 4'h0
`define TMR_RST_VAL 24'h000000
`define TMR_CNT_MAX 24'hffffff
`define TMR_RST_WORD 32'h00000000

// AHB transfer type bit that marks an active transfer
`define TMR_HTRANS_ACT 1

`endif

// [src/tmr_timer.v]
// Functional notes
// - The pin works as a general-purpose pin only while the mode field is all zero.
// - In timer modes a counter match with the compare value raises a compare interrupt when its enable is set, and none when clear.
// - The counter starts at the load value N, so a compare value M matches after M-N+1 events.
// - An event taking the 24-bit counter from all ones to zero raises an overflow interrupt when its enable is set.
// - Setting the run enable starts the timer and clears the counter; counting follows the mode code.
// - With run enable clear the timer stays stopped, and run enable and both interrupt enables reset to zero.
// - When all three channels are stopped and none is in general-purpose mode, the pin is released.
// - In mode 0 as input the pin level is reported as is, or inverted when the invert bit is set.
// - In mode 0 as output the written bit is driven as is, or inverted when the invert bit is set.
// - In modes 1 to 3 as input the counter steps on rising pin edges, or falling edges when inverted.
// - In mode 2 as output the initial level is driven as is, or inverted when the invert bit is set.
// - Mode 4 measures the high pulse width, or the low pulse width when inverted.
// - Mode 5 measures the period between rising edges, or falling edges when inverted.
`timescale 1ns/10ps
`include "tmr_consts.vh"

module tmr_timer (
   // Clock and reset
   input wire hclk,
   input wire hresetn,
   // AHB-Lite slave
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   // Timer pin
   input wire timer_io_pin_in,
   output reg timer_io_pin_out,
   output reg timer_io_pin_oe,
   // Other two channels stopped and not in gpio mode
   input wire others_quiet,
   // Interrupt requests
   output reg compare_irq,
   output reg overflow_irq
);

   // Control fields
   reg counter_run_enable;
   reg overflow_irq_enable;
   reg compare_irq_enable;
   reg [3:0] mode_select_field;
   reg polarity_invert;
   reg pin_dir_out;
   reg gpio_out_bit;
   reg compare_flag;
   reg overflow_flag;
   reg [23:0] load_value;
   reg [23:0] compare_value;
   reg [23:0] counter;
   reg [23:0] capture;
   reg first_event;
   reg measuring;
   reg toggle_level;
   reg pulse_level;
   // Bus phase state
   reg wr_pend;
   reg rd_pend;
   reg [3:0] dp_addr;
   // Pin synchroniser and edge history
   reg pin_meta;
   reg pin_sync;
   reg pin_prev;

   wire addr_ok;
   wire sel_ctrl;
   wire te_set;
   wire flag_clr_c;
   wire flag_clr_o;
   wire lvl;
   wire lvl_prev;
   wire rise;
   wire fall;
   wire gpio_mode;
   wire timer_mode;
   wire ext_src;
   wire tick;
   wire step;
   wire load_now;
   wire [23:0] next_counter;
   wire cmp_hit;
   wire ovf_hit;
   wire [31:0] ctrl_word;

   // Address phase acceptance and write decode
   assign addr_ok = hsel & htrans[`TMR_HTRANS_ACT] & hready;
   assign sel_ctrl = wr_pend & (dp_addr == `TMR_OFS_CTRL);
   assign te_set = sel_ctrl & hwdata[`TMR_BIT_RUN] &
                   ~counter_run_enable;
   assign flag_clr_c = sel_ctrl & hwdata[`TMR_BIT_CMP_FLAG];
   assign flag_clr_o = sel_ctrl & hwdata[`TMR_BIT_OVF_FLAG];

   // Polarity-corrected pin level and edges
   assign lvl = pin_sync ^ polarity_invert;
   assign lvl_prev = pin_prev ^ polarity_invert;
   assign rise = lvl & ~lvl_prev;
   assign fall = ~lvl & lvl_prev;

   // Mode decode
   assign gpio_mode = (mode_select_field == `TMR_MODE_GPIO);
   assign timer_mode = (mode_select_field == `TMR_MODE_PULSE) |
                       (mode_select_field == `TMR_MODE_TOGGLE) |
                       (mode_select_field == `TMR_MODE_EVENT);
   // Event counter always counts pin edges; modes 1, 2 do when input
   assign ext_src = (mode_select_field == `TMR_MODE_EVENT) |
                    ~pin_dir_out;
   assign tick = counter_run_enable & timer_mode &
                 (ext_src ? rise : 1'b1);

   // Counting step: timer events, or clock cycles while measuring
   assign load_now = tick & first_event;
   // Period mode keeps counting through the opposite pin edge
   assign step = (tick & ~first_event) |
                 (counter_run_enable & measuring & ~rise &
                  ~(fall & (mode_select_field == `TMR_MODE_WIDTH)) &
                  ((mode_select_field == `TMR_MODE_WIDTH) |
                   (mode_select_field == `TMR_MODE_PERIOD)));
   assign next_counter = load_now ? load_value :
                         counter + 24'h000001;
   assign cmp_hit = tick & (next_counter == compare_value);
   assign ovf_hit = step & (counter == `TMR_CNT_MAX);

   // Read view of the control/status word
   assign ctrl_word = {18'h00000, overflow_flag, compare_flag,
                       gpio_mode & ~pin_dir_out & lvl, gpio_out_bit,
                       pin_dir_out, polarity_invert, mode_select_field,
                       1'b0, compare_irq_enable, overflow_irq_enable,
                       counter_run_enable};

   // Bus slave: writes zero-wait, reads take one wait state
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         rd_pend <= 1'b0;
         dp_addr <= 4'h0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= `TMR_RST_WORD;
      end else begin
         hresp <= 1'b0;
         if (rd_pend) begin
            rd_pend <= 1'b0;
            hreadyout <= 1'b1;
            case (dp_addr)
               `TMR_OFS_CTRL: hrdata <= ctrl_word;
               `TMR_OFS_LOAD: hrdata <= {8'h00, load_value};
               `TMR_OFS_CMP: hrdata <= {8'h00, compare_value};
               `TMR_OFS_COUNT: begin
                  if (measuring | ~timer_mode & ~gpio_mode)
                     hrdata <= {8'h00, capture};
                  else
                     hrdata <= {8'h00, counter};
               end
               default: hrdata <= `TMR_RST_WORD;
            endcase
         end else begin
            wr_pend <= addr_ok & hwrite;
            rd_pend <= addr_ok & ~hwrite;
            hreadyout <= ~(addr_ok & ~hwrite);
            if (addr_ok)
               dp_addr <= (haddr[31:4] == 28'h0000000) ?
                          haddr[3:0] : 4'h3;
         end
      end
   end

   // Control register fields
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         counter_run_enable <= 1'b0;
         overflow_irq_enable <= 1'b0;
         compare_irq_enable <= 1'b0;
         mode_select_field <= `TMR_RST_MODE;
         polarity_invert <= 1'b0;
         pin_dir_out <= 1'b0;
         gpio_out_bit <= 1'b0;
         load_value <= `TMR_RST_VAL;
         compare_value <= `TMR_RST_VAL;
      end else if (wr_pend) begin
         case (dp_addr)
            `TMR_OFS_CTRL: begin
               counter_run_enable <= hwdata[`TMR_BIT_RUN];
               overflow_irq_enable <= hwdata[`TMR_BIT_OVF_IE];
               compare_irq_enable <= hwdata[`TMR_BIT_CMP_IE];
               mode_select_field <=
                  hwdata[`TMR_MODE_HI:`TMR_MODE_LO];
               polarity_invert <= hwdata[`TMR_BIT_INV];
               pin_dir_out <= hwdata[`TMR_BIT_DIR];
               gpio_out_bit <= hwdata[`TMR_BIT_GPO];
            end
            `TMR_OFS_LOAD: load_value <= hwdata[23:0];
            `TMR_OFS_CMP: compare_value <= hwdata[23:0];
            default: load_value <= load_value;
         endcase
      end
   end

   // Sticky flags: a new hit wins over a clear in the same cycle
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         compare_flag <= 1'b0;
         overflow_flag <= 1'b0;
         compare_irq <= 1'b0;
         overflow_irq <= 1'b0;
      end else begin
         compare_flag <= (compare_flag & ~flag_clr_c) | cmp_hit;
         overflow_flag <= (overflow_flag & ~flag_clr_o) | ovf_hit;
         compare_irq <= compare_irq_enable & compare_flag;
         overflow_irq <= overflow_irq_enable & overflow_flag;
      end
   end

   // Counter, measurement capture and output waveform state
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         counter <= `TMR_RST_VAL;
         capture <= `TMR_RST_VAL;
         first_event <= 1'b1;
         measuring <= 1'b0;
         toggle_level <= 1'b0;
         pulse_level <= 1'b0;
      end else if (te_set) begin
         counter <= `TMR_RST_VAL;
         first_event <= 1'b1;
         measuring <= 1'b0;
         toggle_level <= 1'b0;
         pulse_level <= 1'b0;
      end else if (counter_run_enable) begin
         pulse_level <= cmp_hit &
            (mode_select_field == `TMR_MODE_PULSE);
         if (cmp_hit & (mode_select_field == `TMR_MODE_TOGGLE))
            toggle_level <= ~toggle_level;
         case (mode_select_field)
            `TMR_MODE_PULSE, `TMR_MODE_TOGGLE, `TMR_MODE_EVENT: begin
               if (tick) begin
                  counter <= next_counter;
                  first_event <= 1'b0;
               end
            end
            `TMR_MODE_WIDTH: begin
               if (rise) begin
                  counter <= load_value;
                  measuring <= 1'b1;
               end else if (fall & measuring) begin
                  capture <= counter;
                  measuring <= 1'b0;
               end else if (step)
                  counter <= next_counter;
            end
            `TMR_MODE_PERIOD: begin
               if (rise) begin
                  if (measuring)
                     capture <= counter;
                  counter <= load_value;
                  measuring <= 1'b1;
               end else if (step)
                  counter <= next_counter;
            end
            default: measuring <= 1'b0;
         endcase
      end else begin
         pulse_level <= 1'b0;
         measuring <= 1'b0;
      end
   end

   // Pin synchroniser: first stage feeds only the second
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_meta <= 1'b0;
         pin_sync <= 1'b0;
         pin_prev <= 1'b0;
      end else begin
         pin_meta <= timer_io_pin_in;
         pin_sync <= pin_meta;
         pin_prev <= pin_sync;
      end
   end

   // Pin drive level and enable
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         timer_io_pin_out <= 1'b0;
         timer_io_pin_oe <= 1'b0;
      end else begin
         case (mode_select_field)
            `TMR_MODE_GPIO:
               timer_io_pin_out <= gpio_out_bit ^ polarity_invert;
            `TMR_MODE_PULSE:
               timer_io_pin_out <= pulse_level ^ polarity_invert;
            `TMR_MODE_TOGGLE:
               timer_io_pin_out <= toggle_level ^ polarity_invert;
            default: timer_io_pin_out <= polarity_invert;
         endcase
         if (gpio_mode)
            timer_io_pin_oe <= pin_dir_out;
         else
            timer_io_pin_oe <= pin_dir_out &
               ((mode_select_field == `TMR_MODE_PULSE) |
                (mode_select_field == `TMR_MODE_TOGGLE)) &
               (counter_run_enable | ~others_quiet);
      end
   end

endmodule // tmr_timer

// [verification/timer_control_and_pin_polarity_tb_top.sv]
`timescale 1ns/10ps
`include "tmr_consts.vh"
module timer_control_and_pin_polarity_tb_top;
   reg hclk = 1'b0;
   reg hresetn = 1'b0;
   reg hsel = 1'b0;
   reg [31:0] haddr = 32'h00000000;
   reg [1:0] htrans = 2'h0;
   reg hwrite = 1'b0;
   reg [2:0] hsize = 3'h2;
   reg [31:0] hwdata = 32'h00000000;
   reg src = 1'b0;
   reg quiet = 1'b1;
   wire hready, hresp, pin_in, pin_out, pin_oe, cmp_irq, ovf_irq;
   wire [31:0] hrdata;
   integer bad_count = 0, tests_run = 0, i, k;
   reg [31:0] seed = 32'h7ff43bd6, rd, n, w;
   // Clock of 50 ns
   always #25 hclk = ~hclk;
   tmr_timer dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hready), .hresp(hresp), .timer_io_pin_in(pin_in),
      .timer_io_pin_out(pin_out), .timer_io_pin_oe(pin_oe),
      .others_quiet(quiet), .compare_irq(cmp_irq), .overflow_irq(ovf_irq));
   tmr_pin_model pin_u (.src_lvl(src), .pin_out(pin_out), .pin_oe(pin_oe),
      .pin_in(pin_in));
   function [31:0] lfsr(input [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task wt(input integer c);
      repeat (c) @(posedge hclk);
   endtask
   // One single transfer, address then data phase
   task bus(input wr, input [31:0] a, input [31:0] d, output [31:0] r);
      @(posedge hclk);
      hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= wr;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      r = hrdata;
   endtask
   task wr(input [31:0] a, input [31:0] d);
      bus(1'b1, a, d, rd);
   endtask
   task chk(input string nm, input [31:0] e, input [31:0] g);
      tests_run++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Pin pulse that returns to its idle level
   task pulse;
      src <= ~src; wt(5);
      src <= ~src; wt(5);
   endtask
   task print_verdict;
      $display("tests %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Main sequence
   initial begin
      wt(10); hresetn <= 1'b1;
      bus(1'b0, `TMR_OFS_CTRL, 0, rd); chk("ctrl reset", `TMR_RST_WORD, rd);
      bus(1'b0, 32'h00000010, 0, rd); chk("unmapped", 0, rd);
      $display("test reset done");
      for (i = 0; i < 4; i++) begin
         seed = lfsr(seed); src <= seed[0];
         w = {23'h0, i[0], 8'h00}; wr(0, w); wt(5); bus(1'b0, 0, 0, rd);
         chk("gpio in", w | {20'h0, seed[0] ^ i[0], 11'h0}, rd);
         w = w | 32'h00000200 | {21'h0, seed[1], 10'h0}; wr(0, w); wt(3);
         chk("gpio out", seed[1] ^ i[0], pin_out);
         chk("gpio oe", 1, pin_oe);
      end
      quiet <= 1'b0; wr(0, 32'h00000210); wt(3); chk("drive", 1, pin_oe);
      quiet <= 1'b1; wt(3); chk("release", 0, pin_oe);
      wr(0, 32'h00000320); wt(3); chk("init out", 1, pin_out);
      wr(0, 32'h00000010); src <= 1'b1; wt(5); bus(1'b0, 0, 0, rd);
      chk("no gpio", 32'h00000010, rd);
      $display("test pin polarity done");
      for (i = 0; i < 6; i++) begin
         seed = lfsr(seed); n = {9'h0, seed[22:0]}; k = seed[25:24] + 1;
         wr(0, 32'h00003000); src <= i[0]; wr(4, n); wr(8, n + k);
         w = {23'h0, i[0], 8'h05}; w[7:4] = i / 2 + 1; wr(0, w);
         repeat (k) pulse;
         chk("early irq", 0, cmp_irq);
         pulse; chk("cmp irq", 1, cmp_irq);
         bus(1'b0, 32'h0000000c, 0, rd); chk("count", n + k, rd);
      end
      $display("test event count done");
      wr(0, 32'h00003000); src <= 1'b0; wr(4, `TMR_CNT_MAX);
      wr(0, 32'h00000033); pulse;
      chk("ovf early", 0, ovf_irq);
      pulse; chk("ovf irq", 1, ovf_irq);
      wr(0, 32'h00003030); pulse; bus(1'b0, 32'h0000000c, 0, rd);
      chk("stopped", 0, rd);
      $display("test overflow done");
      // Width (mode 4) and period (mode 5), both polarities
      for (i = 0; i < 4; i++) begin
         seed = lfsr(seed); n = {12'h0, seed[19:0]}; k = seed[28:24] + 4;
         wr(0, 32'h00003000); src <= i[0]; wr(4, n);
         wr(0, {23'h0, i[0], 4'h4 + i[1], 4'h1}); wt(4);
         if (i[1]) begin
            src <= ~i[0]; wt(3); src <= i[0]; wt(k - 3);
            src <= ~i[0]; wt(6); src <= i[0];
         end else begin
            src <= ~i[0]; wt(k); src <= i[0]; wt(6);
         end
         bus(1'b0, 32'h0000000c, 0, rd);
         chk("measure", n + k - 1, rd);
      end
      $display("test measurement done");
      print_verdict;
   end
   // Watchdog well beyond the several hundred cycles the tests need
   initial begin
      wt(20000);
      bad_count++;
      print_verdict;
   end
endmodule // timer_control_and_pin_polarity_tb_top

// [verification/tmr_pin_model.sv]
`timescale 1ns/10ps
module tmr_pin_model (
   // Source level and design drive
   input wire src_lvl,
   input wire pin_out,
   input wire pin_oe,
   // Resolved pin level
   output wire pin_in
);
   // Design wins while driving, else the outside source sets the level
   assign pin_in = pin_oe ? pin_out : src_lvl;
endmodule // tmr_pin_model

// [verification/tmr_timer_monitor.sv]
`timescale 1ns/10ps
module tmr_timer_monitor (
   // Clock and reset
   input wire hclk,
   input wire hresetn,
   // Bus
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [31:0] hwdata,
   input wire hready,
   input wire hreadyout,
   input wire hresp,
   // Pin and status
   input wire timer_io_pin_out,
   input wire timer_io_pin_oe,
   input wire others_quiet,
   input wire compare_irq,
   input wire overflow_irq
);
   reg ctl_wr;
   reg [31:0] ctl;
   reg [1:0] age;
   wire take = hsel & htrans[1] & hready;
   wire settled = age == 2'h3;
   wire mode0 = ctl[7:4] == 4'h0;
   // Shadow of the control word and cycles since it changed
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctl_wr <= 1'b0;
         ctl <= 32'h00000000;
         age <= 2'h0;
      end else if (hready) begin
         ctl_wr <= take & hwrite & (haddr == 32'h00000000);
         if (ctl_wr) begin
            ctl <= hwdata;
            age <= 2'h0;
         end else if (!settled) begin
            age <= age + 2'h1;
         end
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence rd_take; take && !hwrite; endsequence
   sequence one_wait; !hreadyout ##1 hreadyout; endsequence
   okay_resp_a: assert property (!hresp)
      else $error("hresp not okay");
   read_wait_a: assert property (rd_take |=> one_wait)
      else $error("read wait state wrong");
   write_nowait_a: assert property (take && hwrite |=> hreadyout)
      else $error("write stalled");
   cmp_irq_off_a: assert property (!ctl[2] [*3] |-> !compare_irq)
      else $error("compare irq while disabled");
   ovf_irq_off_a: assert property (!ctl[1] [*3] |-> !overflow_irq)
      else $error("overflow irq while disabled");
   gpio_dir_a: assert property (settled && mode0 |-> timer_io_pin_oe == ctl[9])
      else $error("gpio direction wrong");
   gpio_out_a: assert property (settled && mode0 && ctl[9] |->
      timer_io_pin_out == (ctl[10] ^ ctl[8]))
      else $error("gpio output level wrong");
   pin_release_a: assert property ((settled && !mode0 && !ctl[0] &&
      others_quiet) [*2] |-> !timer_io_pin_oe)
      else $error("pin not released");
endmodule // tmr_timer_monitor
bind tmr_timer tmr_timer_monitor mon_u (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .timer_io_pin_out(timer_io_pin_out), .timer_io_pin_oe(timer_io_pin_oe),
   .others_quiet(others_quiet), .compare_irq(compare_irq),
   .overflow_irq(overflow_irq));
